// >>> logic/mmd_decoder.sv
`timescale 1ns/10ps
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter int ADDR_W = MMD_ADDR_W
)(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // cpu bus
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rd,
  input  wire logic              i_wr,
  input  wire logic [7:0]        i_wdata,
  // status inputs from outside logic
  input  wire logic              i_can_asleep_flag,
  input  wire logic              i_nvm_option_byte_load,
  input  wire logic [7:0]        i_nvm_option_byte,
  // decoded selects and read data
  output logic [MMD_SEL_W-1:0]   o_sel,
  output logic                   o_stack_hit,
  output logic                   o_ctrl_rdata_vld,
  output logic [7:0]             o_rdata,
  output logic                   o_nvm_rd_blocked,
  // nvm control
  output logic                   o_nvm_wr_en,
  output logic [ADDR_W-1:0]      o_nvm_addr,
  output logic                   o_nvm_pump_enable,
  output logic                   o_nvm_erase_select,
  output logic                   o_nvm_latch_enable,
  output logic                   o_bus_clock_out_select,
  output logic                   o_wired_or_irq_enable
);

  // inclusive range test, used for every region
  function automatic logic in_rng(input logic [ADDR_W-1:0] a,
                                  input logic [13:0] lo, input logic [13:0] hi);
    in_rng = (a >= ADDR_W'(lo)) && (a <= ADDR_W'(hi));
  endfunction

  logic [MMD_SEL_W-1:0] next_sel;
  logic                 ctrl_hit;
  logic                 nvm_prot_hit;
  logic                 upper_protect;
  logic                 addr_locked;
  logic                 next_erase;
  logic                 next_latch;
  logic                 next_pump;

  // strobes, lock and readback helpers
  logic                 ctrl_wr;
  logic                 ctrl_rd;
  logic                 nvm_rd_latched;
  logic                 nvm_take;
  logic [7:0]           ctrl_word;
  logic [2:0]           asleep_sync;
  logic                 asleep_agreed;

  // combinational region decode across whole space
  always_comb begin
    next_sel                 = '0;
    next_sel[MMD_SEL_PERIPH] = in_rng(i_addr, MMD_PERIPH_LO, MMD_PERIPH_HI);
    next_sel[MMD_SEL_CAN]    = in_rng(i_addr, MMD_CAN_LO, MMD_CAN_HI);
    next_sel[MMD_SEL_RAM0]   = in_rng(i_addr, MMD_RAM0_LO, MMD_RAM0_HI);
    next_sel[MMD_SEL_RAM1]   = in_rng(i_addr, MMD_RAM1_LO, MMD_RAM1_HI);
    next_sel[MMD_SEL_ROM]    = in_rng(i_addr, MMD_ROM_LO, MMD_ROM_HI);
    next_sel[MMD_SEL_VEC]    = in_rng(i_addr, MMD_VEC_LO, MMD_VEC_HI);
    next_sel[MMD_SEL_BOOT0]  = in_rng(i_addr, MMD_BOOT0_LO, MMD_BOOT0_HI);
    next_sel[MMD_SEL_BOOT1]  = in_rng(i_addr, MMD_BOOT1_LO, MMD_BOOT1_HI);
    next_sel[MMD_SEL_NVM]    = in_rng(i_addr, MMD_NVM_LO, MMD_NVM_HI);
  end

  assign ctrl_hit     = (i_addr == ADDR_W'(MMD_NVM_CTRL_ADDR));
  assign nvm_prot_hit = in_rng(i_addr, MMD_NVM_PROT_LO, MMD_NVM_HI);

  // control register strobes, shared by the storage and readback paths
  assign ctrl_wr        = i_wr & ctrl_hit;
  assign ctrl_rd        = i_rd & ctrl_hit;
  // array read while latched gives the busy pattern, not array data
  assign nvm_rd_latched = i_rd & next_sel[MMD_SEL_NVM] & o_nvm_latch_enable;

  // an array write is taken only while latched, unlocked and, in the
  // upper part, unprotected; everything else is dropped
  assign nvm_take = o_nvm_latch_enable & i_wr & next_sel[MMD_SEL_NVM] & ~addr_locked
                    & ~(upper_protect & nvm_prot_hit);

  // the asleep flag comes from the can_controller clock, so it crosses
  // three flops; only the second stage reads the first, and a change
  // counts once the last two agree, which rejects a one-cycle glitch
  // at the cost of four cycles of readback delay
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      asleep_sync <= '0;
    end else begin
      asleep_sync <= {asleep_sync[1:0], i_can_asleep_flag};
    end
  end

  // filtered flag; holds while the last two stages disagree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      asleep_agreed <= 1'b0;
    end else if (asleep_sync[1] == asleep_sync[2]) begin
      asleep_agreed <= asleep_sync[2];
    end
  end

  // registered selects; unmapped gives all-zero select so nothing responds
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sel <= '0;
    end else if (i_rd | i_wr) begin
      o_sel <= next_sel;
    end else begin
      o_sel <= '0;
    end
  end

  // stack window flag; the stack shares the first RAM array
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_stack_hit <= 1'b0;
    end else begin
      o_stack_hit <= (i_rd | i_wr) & in_rng(i_addr, MMD_STACK_LO, MMD_STACK_HI);
    end
  end

  // protect bit captured from option byte at reset-time load; a cleared
  // bit means the upper part is protected, hence reset value protects
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      upper_protect <= MMD_PROTECT_RST;
    end else if (i_nvm_option_byte_load) begin
      upper_protect <= ~i_nvm_option_byte[MMD_OPT_PROT_BIT];
    end
  end

  // latch next value follows every control write
  always_comb begin
    next_latch = o_nvm_latch_enable;
    if (ctrl_wr) begin
      next_latch = i_wdata[MMD_BIT_LATCH];
    end
  end

  // erase select frozen once the target address is taken; falls with
  // the latch
  always_comb begin
    next_erase = o_nvm_erase_select;
    if (ctrl_wr && !addr_locked) begin
      next_erase = i_wdata[MMD_BIT_ERASE];
    end
    if (!next_latch) begin
      next_erase = 1'b0;
    end
  end

  // pump may only start after the target byte is chosen, and only
  // stops through the latch
  always_comb begin
    next_pump = o_nvm_pump_enable;
    if (ctrl_wr && addr_locked && i_wdata[MMD_BIT_PUMP]) begin
      next_pump = 1'b1;
    end
    if (!next_latch) begin
      next_pump = 1'b0;
    end
  end

  // latch bit; clearing it is the only way to end a program or erase
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_latch_enable <= MMD_NVM_CTRL_RST[MMD_BIT_LATCH];
    end else begin
      o_nvm_latch_enable <= next_latch;
    end
  end

  // erase select storage
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_erase_select <= MMD_NVM_CTRL_RST[MMD_BIT_ERASE];
    end else begin
      o_nvm_erase_select <= next_erase;
    end
  end

  // charge pump enable storage
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_pump_enable <= MMD_NVM_CTRL_RST[MMD_BIT_PUMP];
    end else begin
      o_nvm_pump_enable <= next_pump;
    end
  end

  // clock output select, a plain read/write bit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_clock_out_select <= MMD_NVM_CTRL_RST[MMD_BIT_CLKOUT];
    end else if (ctrl_wr) begin
      o_bus_clock_out_select <= i_wdata[MMD_BIT_CLKOUT];
    end
  end

  // wired-or interrupt enable, a plain read/write bit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wired_or_irq_enable <= MMD_NVM_CTRL_RST[MMD_BIT_WOR_IRQ];
    end else if (ctrl_wr) begin
      o_wired_or_irq_enable <= i_wdata[MMD_BIT_WOR_IRQ];
    end
  end

  // one byte per latch session: the first write locks the address and
  // later writes are dropped until the latch drops, so no bulk or row
  // erase can ever be built from successive writes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_locked <= 1'b0;
    end else if (!o_nvm_latch_enable) begin
      addr_locked <= 1'b0;
    end else if (nvm_take) begin
      addr_locked <= 1'b1;
    end
  end

  // target address, held for the array while the latch stands
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_addr <= '0;
    end else if (nvm_take) begin
      o_nvm_addr <= i_addr;
    end
  end

  // one-cycle strobe per accepted target byte
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_wr_en <= 1'b0;
    end else begin
      o_nvm_wr_en <= nvm_take;
    end
  end

  // control word as the cpu sees it; unused bits read as zero
  always_comb begin
    ctrl_word                  = '0;
    ctrl_word[MMD_BIT_PUMP]    = o_nvm_pump_enable;
    ctrl_word[MMD_BIT_LATCH]   = o_nvm_latch_enable;
    ctrl_word[MMD_BIT_ERASE]   = o_nvm_erase_select;
    ctrl_word[MMD_BIT_CLKOUT]  = o_bus_clock_out_select;
    ctrl_word[MMD_BIT_ASLEEP]  = asleep_agreed;
    ctrl_word[MMD_BIT_WOR_IRQ] = o_wired_or_irq_enable;
  end

  // read data: control word, busy pattern for a latched array, else a
  // harmless constant; array contents come from the array itself
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= MMD_UNMAPPED_DATA;
    end else if (ctrl_rd) begin
      o_rdata <= ctrl_word;
    end else if (nvm_rd_latched) begin
      o_rdata <= MMD_NVM_BUSY_DATA;
    end else begin
      o_rdata <= MMD_UNMAPPED_DATA;
    end
  end

  // marks a cycle whose read data is the control word
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ctrl_rdata_vld <= 1'b0;
    end else begin
      o_ctrl_rdata_vld <= ctrl_rd;
    end
  end

  // marks an array read refused because the latch stands
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_rd_blocked <= 1'b0;
    end else begin
      o_nvm_rd_blocked <= nvm_rd_latched;
    end
  end

endmodule

// >>> logic/mmd_pkg.sv
package mmd_pkg;
  // address space
  localparam int          MMD_ADDR_W       = 14;
  localparam int          MMD_SPACE_BYTES  = 16384;
  // region bounds
  localparam logic [13:0] MMD_PERIPH_LO    = 14'h0000;
  localparam logic [13:0] MMD_PERIPH_HI    = 14'h001F;
  localparam logic [13:0] MMD_CAN_LO       = 14'h0020;
  localparam logic [13:0] MMD_CAN_HI       = 14'h003D;
  localparam logic [13:0] MMD_RAM0_LO      = 14'h0050;
  localparam logic [13:0] MMD_RAM0_HI      = 14'h00FF;
  localparam logic [13:0] MMD_STACK_LO     = 14'h00C0;
  localparam logic [13:0] MMD_STACK_HI     = 14'h00FF;
  localparam logic [13:0] MMD_NVM_LO       = 14'h0100;
  localparam logic [13:0] MMD_NVM_HI       = 14'h01FF;
  localparam logic [13:0] MMD_NVM_PROT_LO  = 14'h0120;
  localparam logic [13:0] MMD_OPTION_ADDR  = 14'h0100;
  localparam logic [13:0] MMD_BOOT0_LO     = 14'h0200;
  localparam logic [13:0] MMD_BOOT0_HI     = 14'h024F;
  localparam logic [13:0] MMD_RAM1_LO      = 14'h0250;
  localparam logic [13:0] MMD_RAM1_HI      = 14'h02FF;
  localparam logic [13:0] MMD_ROM_LO       = 14'h0300;
  localparam logic [13:0] MMD_ROM_HI       = 14'h3DFD;
  localparam logic [13:0] MMD_BOOT1_LO     = 14'h3DFE;
  localparam logic [13:0] MMD_BOOT1_HI     = 14'h3FEF;
  localparam logic [13:0] MMD_VEC_LO       = 14'h3FF0;
  localparam logic [13:0] MMD_VEC_HI       = 14'h3FFF;
  // control register
  localparam logic [13:0] MMD_NVM_CTRL_ADDR = 14'h0007;
  localparam logic [7:0]  MMD_NVM_CTRL_RST  = 8'h00;
  localparam int          MMD_BIT_PUMP      = 0;
  localparam int          MMD_BIT_LATCH     = 1;
  localparam int          MMD_BIT_ERASE     = 2;
  localparam int          MMD_BIT_CLKOUT    = 3;
  localparam int          MMD_BIT_ASLEEP    = 6;
  localparam int          MMD_BIT_WOR_IRQ   = 7;
  localparam int          MMD_OPT_PROT_BIT  = 1;
  localparam logic        MMD_PROTECT_RST   = 1'b1;
  localparam logic [7:0]  MMD_NVM_BUSY_DATA = 8'hFF;
  localparam logic [7:0]  MMD_UNMAPPED_DATA = 8'h00;
  // region one-hot select positions
  localparam int          MMD_SEL_W      = 9;
  localparam int          MMD_SEL_PERIPH = 0;
  localparam int          MMD_SEL_CAN    = 1;
  localparam int          MMD_SEL_RAM0   = 2;
  localparam int          MMD_SEL_RAM1   = 3;
  localparam int          MMD_SEL_ROM    = 4;
  localparam int          MMD_SEL_VEC    = 5;
  localparam int          MMD_SEL_BOOT0  = 6;
  localparam int          MMD_SEL_BOOT1  = 7;
  localparam int          MMD_SEL_NVM    = 8;
endpackage

// >>> sim/mmd_cpu_model.sv
`timescale 1ns/10ps
module mmd_cpu_model (
  // bus clock
  input  wire logic i_clk,
  // address, strobes and write data
  output logic [13:0] o_addr  = 14'h0000,
  output logic        o_rd    = 1'b0,
  output logic        o_wr    = 1'b0,
  output logic [7:0]  o_wdata = 8'h00
);
  // one access: strobe for a single cycle, then scramble the idle bus
  task automatic cyc(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_rd <= !w;
    o_wr <= w;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a; // stale address must not be mistaken for a live one
    o_wdata <= ~d;
  endtask
endmodule

// >>> sim/mmd_monitor.sv
`timescale 1ns/10ps
module mmd_monitor
  import mmd_pkg::*;
#(
  parameter int ADDR_W = MMD_ADDR_W
)(
  // clock, reset and cpu bus
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic                 i_rd,
  input  wire logic                 i_wr,
  input  wire logic [7:0]           i_wdata,
  // decoder answers
  input  wire logic [MMD_SEL_W-1:0] o_sel,
  input  wire logic                 o_stack_hit,
  input  wire logic [7:0]           o_rdata,
  input  wire logic                 o_nvm_wr_en,
  input  wire logic                 o_nvm_latch_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // any access; only then are the selects meaningful
  wire acc = i_rd | i_wr;
  function automatic logic in_rng(logic [ADDR_W-1:0] a, logic [13:0] lo, logic [13:0] hi);
    return a >= lo && a <= hi;
  endfunction
  periph_sel_a: assert property (
    acc && in_rng(i_addr, 14'h0000, 14'h001F) |=> o_sel == 9'h001) else $error("periph sel");
  can_sel_a: assert property (
    acc && in_rng(i_addr, 14'h0020, 14'h003D) |=> o_sel == 9'h002) else $error("can sel");
  ram_sel_a: assert property (
    acc && (in_rng(i_addr, 14'h0050, 14'h00FF) || in_rng(i_addr, 14'h0250, 14'h02FF))
    |=> o_sel == (in_rng($past(i_addr), 14'h0050, 14'h00FF) ? 9'h004 : 9'h008))
    else $error("ram sel");
  stack_hit_a: assert property (
    acc |=> o_stack_hit == in_rng($past(i_addr), 14'h00C0, 14'h00FF)) else $error("stack hit");
  rom_sel_a: assert property (
    acc && in_rng(i_addr, 14'h0300, 14'h3DFD) |=> o_sel == 9'h010) else $error("rom sel");
  vec_sel_a: assert property (
    acc && in_rng(i_addr, 14'h3FF0, 14'h3FFF) |=> o_sel == 9'h020) else $error("vec sel");
  boot_sel_a: assert property (
    acc && (in_rng(i_addr, 14'h0200, 14'h024F) || in_rng(i_addr, 14'h3DFE, 14'h3FEF))
    |=> o_sel == (in_rng($past(i_addr), 14'h0200, 14'h024F) ? 9'h040 : 9'h080))
    else $error("boot sel");
  nvm_sel_a: assert property (
    acc && in_rng(i_addr, 14'h0100, 14'h01FF) |=> o_sel == 9'h100) else $error("nvm sel");
  gap_quiet_a: assert property (
    acc && in_rng(i_addr, 14'h003E, 14'h004F) |=> o_sel == 9'h000 && o_rdata == 8'h00)
    else $error("unmapped access");
  latch_write_a: assert property (
    i_wr && i_addr == 14'h0007 |=> o_nvm_latch_enable == $past(i_wdata[1])) else $error("latch");
  single_byte_a: assert property (
    o_nvm_wr_en |-> o_nvm_latch_enable ##1 !o_nvm_wr_en) else $error("second nvm byte");
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  import mmd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, asleep = 1'b0, opt_ld = 1'b0;
  logic [7:0] opt = 8'h00, wdata, rdata;
  logic [13:0] addr, naddr;
  logic [8:0] sel;
  logic rd, wr, stk, vld, blk, wen, pump, era, lat, clko, woi;
  int errors = 0, compares = 0;
  localparam logic [13:0] RA [16] = '{14'h0000, 14'h001F, 14'h0020, 14'h003D, 14'h003E,
    14'h004F, 14'h00BF, 14'h00C0, 14'h01FF, 14'h0250, 14'h0300, 14'h3DFD, 14'h0200,
    14'h3DFE, 14'h3FEF, 14'h3FFF};
  localparam logic [8:0] RS [16] = '{9'h001, 9'h001, 9'h002, 9'h002, 9'h000, 9'h000,
    9'h004, 9'h004, 9'h100, 9'h008, 9'h010, 9'h010, 9'h040, 9'h080, 9'h080, 9'h020};
  mmd_cpu_model cpu_u (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  mmd_decoder dut_u (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .i_can_asleep_flag(asleep), .i_nvm_option_byte_load(opt_ld),
    .i_nvm_option_byte(opt), .o_sel(sel), .o_stack_hit(stk), .o_ctrl_rdata_vld(vld),
    .o_rdata(rdata), .o_nvm_rd_blocked(blk), .o_nvm_wr_en(wen), .o_nvm_addr(naddr),
    .o_nvm_pump_enable(pump), .o_nvm_erase_select(era), .o_nvm_latch_enable(lat),
    .o_bus_clock_out_select(clko), .o_wired_or_irq_enable(woi));
  // 250 MHz bus clock
  initial forever #2 clk = ~clk;
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // whole run is under a hundred cycles; this only catches a hang
  initial begin
    #8000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    asleep <= 1'b1;
    #1 `CHK({woi, clko, era, lat, pump}, 5'h00)
    // let the asleep flag settle through its synchroniser
    repeat (3) @(posedge clk);
    cpu_u.cyc(1'b1, 14'h0007, 8'h88);
    cpu_u.cyc(1'b0, 14'h0007, 8'h00);
    #1 `CHK({vld, rdata}, {1'b1, 8'hC8})
    $display("test control register done");
    for (int k = 0; k < 16; k++) begin
      cpu_u.cyc(k[0], RA[k], 8'h00);
      #1 `CHK(sel, RS[k])
      `CHK(stk, RA[k] >= 14'h00C0 && RA[k] <= 14'h00FF)
      `CHK(rdata, 8'h00)
    end
    $display("test region map done");
    cpu_u.cyc(1'b1, 14'h0007, 8'h07);
    #1 `CHK({era, lat, pump}, 3'h6)
    cpu_u.cyc(1'b1, 14'h0110, 8'h5A);
    #1 `CHK({wen, naddr}, {1'b1, 14'h0110})
    cpu_u.cyc(1'b1, 14'h0111, 8'h5A);
    #1 `CHK(wen, 1'b0)
    cpu_u.cyc(1'b0, 14'h0110, 8'h00);
    #1 `CHK({blk, rdata}, {1'b1, 8'hFF})
    cpu_u.cyc(1'b1, 14'h0007, 8'h03);
    #1 `CHK({era, lat, pump}, 3'h7)
    cpu_u.cyc(1'b1, 14'h0007, 8'h00);
    #1 `CHK({era, lat, pump}, 3'h0)
    $display("test byte erase done");
    cpu_u.cyc(1'b1, 14'h0007, 8'h02);
    cpu_u.cyc(1'b1, 14'h0150, 8'h00);
    #1 `CHK(wen, 1'b0)
    cpu_u.cyc(1'b1, 14'h0007, 8'h00);
    @(posedge clk);
    opt <= 8'h02;
    opt_ld <= 1'b1;
    @(posedge clk);
    opt_ld <= 1'b0;
    cpu_u.cyc(1'b1, 14'h0007, 8'h02);
    cpu_u.cyc(1'b1, 14'h0150, 8'h00);
    #1 `CHK({wen, naddr}, {1'b1, 14'h0150})
    $display("test protection done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 `CHK({woi, clko, era, lat, pump, wen}, 6'h00)
    cpu_u.cyc(1'b1, 14'h0007, 8'h02);
    cpu_u.cyc(1'b1, 14'h0150, 8'h00);
    #1 `CHK(wen, 1'b0)
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
bind mmd_decoder mmd_monitor #(.ADDR_W(ADDR_W)) mon_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_sel(o_sel),
  .o_stack_hit(o_stack_hit), .o_rdata(o_rdata), .o_nvm_wr_en(o_nvm_wr_en),
  .o_nvm_latch_enable(o_nvm_latch_enable));
